// [dv/sdram_burst_properties.sv]
/* Pin-level checks for the burst read engine, bound into the block.
   Assumes only the block's ports and its asynchronous reset. */
`timescale 1ns/100ps
module sdram_burst_properties (
  input wire pclk,
  input wire presetn,
  input wire [25:0] addr_pin_reg,
  input wire cs2_n_reg,
  input wire row_strobe_upper_n_reg,
  input wire row_strobe_lower_n_reg,
  input wire col_strobe_upper_n_reg,
  input wire col_strobe_lower_n_reg,
  input wire rdata_valid_reg,
  input wire rdata_last_reg
);
  wire ras_low = !row_strobe_upper_n_reg || !row_strobe_lower_n_reg;
  wire cas_low = !col_strobe_upper_n_reg || !col_strobe_lower_n_reg;
  reg [25:0] row_pins;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) row_pins <= 26'h000_0000;
    else if (ras_low) row_pins <= addr_pin_reg;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence col_run; cas_low [*4] ##1 !cas_low; endsequence
  sequence cmd_12; !addr_pin_reg[12] [*3] ##1 addr_pin_reg[12]; endsequence
  sequence cmd_11; !addr_pin_reg[11] [*3] ##1 addr_pin_reg[11]; endsequence
  four_columns_a: assert property ($rose(cas_low) |-> col_run)
    else $error("column run length");
  act_to_col_a: assert property ($rose(ras_low) |-> ##[1:4] $rose(cas_low))
    else $error("late column");
  strobe_pair_a: assert property (
    !row_strobe_upper_n_reg |-> ##[1:4] !col_strobe_upper_n_reg)
    else $error("upper strobe pair");
  cmd_bit_a: assert property ($rose(cas_low) |-> cmd_12 or cmd_11)
    else $error("command bit");
  beat_train_a: assert property (
    rdata_last_reg |-> rdata_valid_reg && $past(rdata_valid_reg, 3))
    else $error("beat train");
  fixed_pins_a: assert property (
    cas_low |-> addr_pin_reg[25:17] == row_pins[25:17])
    else $error("fixed pins moved");
  bank_pins_a: assert property (cas_low |-> addr_pin_reg[14] == row_pins[14])
    else $error("bank pin moved");
  precharge_gap_a: assert property ($rose(cs2_n_reg) |-> cs2_n_reg [*3])
    else $error("precharge gap");
endmodule
bind sdram_addr_mux_burst_read sdram_burst_properties i_props (.pclk(pclk),
  .presetn(presetn), .addr_pin_reg(addr_pin_reg), .cs2_n_reg(cs2_n_reg),
  .row_strobe_upper_n_reg(row_strobe_upper_n_reg),
  .row_strobe_lower_n_reg(row_strobe_lower_n_reg),
  .col_strobe_upper_n_reg(col_strobe_upper_n_reg),
  .col_strobe_lower_n_reg(col_strobe_lower_n_reg),
  .rdata_valid_reg(rdata_valid_reg), .rdata_last_reg(rdata_last_reg));

// [dv/sdram_chip_model.sv]
/* Memory chips on the shared bus, answering read commands after the latency.
   Assumes registered controller pins and a latency set by the bench. */
`timescale 1ns/100ps
module sdram_chip_model (
  input wire pclk,
  input wire cmd_n,
  input wire [25:0] pins,
  input wire [1:0] lat,
  output wire [31:0] dq
);
  logic [31:0] pipe [0:3];
  logic [3:0] live = 4'h0;
  logic idle = 1'b0;
  wire [1:0] k = (lat == 2'h0) ? 2'h0 : lat - 2'h1;
  // Released bus toggles each cycle so a stale beat cannot match
  assign dq = live[k] ? pipe[k] : {32{idle}} ^ 32'h5a5a_5a5a;
  always @(posedge pclk) begin
    idle <= !idle;
    live <= {live[2:0], !cmd_n};
    pipe[0] <= {6'h15, pins}; // Memory A0 on pin A2, beat names its column
    for (int i = 1; i < 4; i++) pipe[i] <= pipe[i - 1];
  end
endmodule

// [dv/test_sdram_addr_mux_burst_read.sv]
/* Bench for the burst read engine: APB set-up, bursts against the memory model.
   Assumes the register header and the bound pin checker. */
`timescale 1ns/100ps
`include "sdram_mux_regs.vh"
module test_sdram_addr_mux_burst_read;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rq_v = 0, rq_ar = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, dq, rdata, beats [0:3];
  logic [25:0] rq_a = 26'h000_0000, pins, row_seen;
  logic pready, pslverr, rq_rdy, valid, up_seen, cs2_n, cs3_n, ru_n, rl_n, cu_n, cl_n;
  logic rw, rw_seen, ar_seen;
  logic [1:0] lat = 2'h1;
  int err_count = 0, tests_run = 0, cyc = 0, t_act, t_cas, t_val;
  always #2 pclk = !pclk;
  sdram_addr_mux_burst_read i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(rq_v), .req_area(rq_ar),
    .req_addr(rq_a), .req_ready(rq_rdy), .addr_pin_reg(pins), .cs2_n_reg(cs2_n),
    .cs3_n_reg(cs3_n), .row_strobe_upper_n_reg(ru_n), .row_strobe_lower_n_reg(rl_n),
    .col_strobe_upper_n_reg(cu_n), .col_strobe_lower_n_reg(cl_n), .rd_wr_reg(rw),
    .dq_in(dq), .rdata_reg(rdata), .rdata_valid_reg(valid), .rdata_last_reg());
  sdram_chip_model i_mem (.pclk(pclk), .cmd_n((cs2_n & cs3_n) | (cu_n & cl_n)),
    .pins(pins), .lat(lat), .dq(dq));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb_io(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cfg(input logic [3:0] code, input logic [1:0] act_dly, input logic [2:0] tpc,
      input logic b16, input logic [1:0] cl);
    logic [31:0] q;
    logic e;
    apb_io(1, `MEMORY_CONTROL_OFFSET, {22'h0, b16, tpc, act_dly, code}, q, e);
    apb_io(1, `WAIT_CONTROL_TWO_OFFSET, {28'h0, cl, cl}, q, e);
    lat <= cl;
  endtask
  // Ends at the falling edge of the cycle that shows the fourth beat
  task automatic burst(input logic area, input logic [25:0] a);
    int n = 0;
    @(posedge pclk);
    rq_v <= 1;
    rq_ar <= area;
    rq_a <= a;
    @(negedge pclk);
    while (rq_rdy !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    rq_v <= 0;
    rq_ar <= !area;
    t_cas = 0;
    while (n < 4) begin
      @(negedge pclk);
      if (!(ru_n & rl_n)) begin
        t_act = cyc;
        row_seen = pins;
        up_seen = !ru_n;
        ar_seen = !cs3_n;
      end
      if (!(cu_n & cl_n)) rw_seen = rw;
      if (!(cu_n & cl_n) && t_cas == 0) t_cas = cyc;
      if (valid === 1'b1) begin
        if (n == 0) t_val = cyc;
        beats[n] = rdata;
        n++;
      end
    end
  endtask
  task automatic reg_defaults();
    logic [31:0] q;
    logic e;
    apb_io(0, `MEMORY_CONTROL_OFFSET, 32'h0, q, e);
    check(q, `MEMORY_CONTROL_RESET);
    apb_io(0, `WAIT_CONTROL_TWO_OFFSET, 32'h0, q, e);
    check(q, `WAIT_CONTROL_TWO_RESET);
    apb_io(1, 12'hffc, 32'hffff_ffff, q, e);
    check({31'h0, e}, 32'h1);
  endtask
  task automatic map_check();
    logic [25:0] a, p;
    int n = 0;
    a = 26'h2c5_a7b8;
    cfg(`CODE_1M16, 2'h0, 3'h3, 1'b0, 2'h1);
    burst(1'b0, a);
    p = a;
    p[15:1] = a[23:9];
    check({6'h0, row_seen & 26'h3fe_ffff}, {6'h0, p & 26'h3fe_ffff});
    check({31'h0, ar_seen}, 32'h0);
    check({31'h0, rw_seen}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      p = a;
      p[3:2] = a[3:2] + k[1:0];
      p[12] = (k == 3);
      p[15:14] = a[23:22];
      check(beats[k] & 32'hfffe_ffff, {6'h15, p} & 32'hfffe_ffff);
    end
    check({31'h0, rq_rdy}, 32'h1);
    @(posedge pclk);
    rq_ar <= 0;
    @(negedge pclk);
    while (rq_rdy !== 1'b1 && n < 40) begin
      n++;
      @(negedge pclk);
    end
    check(n, 3);
  endtask
  task automatic timing_sweep();
    for (int i = 1; i < 4; i++) begin
      cfg(`CODE_1M16, 2'(4 - i), 3'h0, 1'b0, 2'(i));
      burst(1'b0, 26'h000_1230);
      check(t_cas - t_act, 5 - i);
      check(t_val - t_cas, i + 1);
    end
  endtask
  task automatic strobe_table();
    logic [3:0] code [0:5] = '{`CODE_BIG, `CODE_2M16, `CODE_1M16, `CODE_512K32, `CODE_8M16,
      `CODE_1M16};
    int lsb [0:5] = '{10, 10, 9, 9, 11, 9};
    logic [25:0] a;
    for (int i = 0; i < 6; i++) begin
      a = (i == 5) ? 26'h000_0a00 : 26'h200_0a00;
      cfg(code[i], 2'h0, 3'h0, i == 4, 2'h1);
      burst(1'b1, a);
      check({31'h0, up_seen}, {31'h0, i inside {1, 2, 3}});
      check({31'h0, ar_seen}, 32'h1);
      check({31'h0, row_seen[1]}, {31'h0, a[lsb[i]]});
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    reg_defaults();
    map_check();
    timing_sweep();
    strobe_table();
    close_out();
  end
endmodule

// [verilog/sdram_addr_mux_burst_read.v]
/*
 * Synchronous DRAM address multiplexer and four-beat burst read engine
 * with auto-precharge, registers reached over APB.
 * Assumes pclk is also the external bus clock toward the memory, and
 * that the memory is wired with its lowest address line on pin A2
 * (32-bit bus) or A1 (16-bit bus).
 */
`timescale 1ns/100ps
`include "sdram_mux_regs.vh"

module sdram_addr_mux_burst_read (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire req_valid,
  input wire req_area,
  input wire [25:0] req_addr,
  output wire req_ready,
  output reg [25:0] addr_pin_reg,
  output reg cs2_n_reg,
  output reg cs3_n_reg,
  output reg row_strobe_upper_n_reg,
  output reg row_strobe_lower_n_reg,
  output reg col_strobe_upper_n_reg,
  output reg col_strobe_lower_n_reg,
  output reg rd_wr_reg,
  input wire [31:0] dq_in,
  output reg [31:0] rdata_reg,
  output reg rdata_valid_reg,
  output reg rdata_last_reg
);

  localparam S_IDLE = 5'b00001;
  localparam S_ACT = 5'b00010;
  localparam S_NOP_WAIT = 5'b00100;
  localparam S_COL = 5'b01000;
  localparam S_DRAIN = 5'b10000;

  reg [31:0] memory_control_reg;
  reg [31:0] wait_control_reg_two;
  reg [4:0] state_reg;
  reg [25:0] acc_addr_reg;
  reg acc_area_reg;
  reg [1:0] wait_reg;
  reg [1:0] beat_reg;
  reg [2:0] cap_reg;
  reg [2:0] issue_pipe_reg;
  reg [3:0] pc2_reg;
  reg [3:0] pc3_reg;

  wire [3:0] addr_mux_code = memory_control_reg[`MUX_CODE_MSB:`MUX_CODE_LSB];
  wire [1:0] act_to_read_delay = memory_control_reg[`ACT_DELAY_MSB:`ACT_DELAY_LSB];
  wire [2:0] tpc = memory_control_reg[`TPC_MSB:`TPC_LSB];
  wire bus16 = memory_control_reg[`BUS16_BIT];
  wire [1:0] cl_raw = acc_area_reg ? wait_control_reg_two[`CL3_MSB:`CL3_LSB] :
                                     wait_control_reg_two[`CL2_MSB:`CL2_LSB];
  // Latency 0 is not a legal memory setting; treat it as 1
  wire [1:0] cas_lat = (cl_raw == 2'h0) ? 2'h1 : cl_raw;
  wire capture = issue_pipe_reg[cas_lat - 2'h1];
  wire last_capture = capture && (cap_reg == `BEATS - 3'h1);
  wire area_free = req_area ? (pc3_reg == 4'h0) : (pc2_reg == 4'h0);

  // Only a precharging area is blocked; the other may start at once
  assign req_ready = (state_reg == S_IDLE) && area_free;
  assign pready = 1'b1;

  wire apb_hit = (paddr == `MEMORY_CONTROL_OFFSET) ||
                 (paddr == `WAIT_CONTROL_TWO_OFFSET) || (paddr == `STATUS_OFFSET);
  assign pslverr = psel && penable && !apb_hit;
  wire apb_wr = psel && penable && pwrite;

  // Row shift and highest multiplexed pin for each geometry
  function [4:0] row_shift;
    input [3:0] code;
    input b16;
    begin
      case (code)
        `CODE_8M16: row_shift = 5'd10;
        `CODE_BIG: row_shift = b16 ? 5'd9 : 5'd9;
        `CODE_2M16: row_shift = 5'd9;
        default: row_shift = 5'd8;
      endcase
    end
  endfunction

  function [4:0] top_pin;
    input [3:0] code;
    input b16;
    begin
      top_pin = (code == `CODE_BIG && !b16) ? 5'd`MUX_HI : 5'd`ODD_PIN;
    end
  endfunction

  // Row phase: multiplexed pins carry the shifted internal address
  function [25:0] row_pins;
    input [25:0] a;
    input [3:0] code;
    input b16;
    integer i;
    begin
      row_pins = a;
      for (i = `MUX_LO; i <= `MUX_HI; i = i + 1) begin
        if (i <= top_pin(code, b16))
          row_pins[i] = a[i + row_shift(code, b16)];
      end
    end
  endfunction

  // Column phase: identity below the command pin, bank bits as in row
  function [25:0] col_pins;
    input [25:0] a;
    input [3:0] code;
    input b16;
    input cmd_bit;
    reg [25:0] r;
    integer cp;
    integer i;
    begin
      r = row_pins(a, code, b16);
      cp = b16 ? `CMD_PIN_16 : `CMD_PIN_32;
      col_pins = a;
      for (i = `MUX_LO; i <= `MUX_HI; i = i + 1) begin
        if (i == cp)
          col_pins[i] = cmd_bit;
        else if (i > cp + 1)
          col_pins[i] = r[i];
      end
      // Here the pin above the command bit is a bank bit, not a column bit
      if (code == `CODE_512K32 && !b16)
        col_pins[`CMD_PIN_32 + 1] = r[`CMD_PIN_32 + 1];
      if ((code == `CODE_512K32 && !b16) || (code == `CODE_1M16 && b16))
        col_pins[`ODD_PIN] = a[`ODD_PIN];
    end
  endfunction

  // Burst wraps inside the 16-byte block (8-byte on a 16-bit bus) starting at the missed word
  function [25:0] beat_addr;
    input [25:0] a;
    input [1:0] k;
    input b16;
    begin
      beat_addr = a;
      if (b16)
        beat_addr[2:1] = a[2:1] + k;
      else
        beat_addr[3:2] = a[3:2] + k;
    end
  endfunction

  function is_big;
    input [3:0] code;
    input b16;
    begin
      is_big = (code == `CODE_BIG && !b16) || (code == `CODE_8M16 && b16);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_control_reg <= `MEMORY_CONTROL_RESET;
      wait_control_reg_two <= `WAIT_CONTROL_TWO_RESET;
    end else if (apb_wr) begin
      if (paddr == `MEMORY_CONTROL_OFFSET)
        memory_control_reg <= pwdata & `MEMORY_CONTROL_MASK;
      if (paddr == `WAIT_CONTROL_TWO_OFFSET)
        wait_control_reg_two <= pwdata & `WAIT_CONTROL_TWO_MASK;
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        `MEMORY_CONTROL_OFFSET: prdata = memory_control_reg;
        `WAIT_CONTROL_TWO_OFFSET: prdata = wait_control_reg_two;
        `STATUS_OFFSET: prdata = {19'h0_0000, pc3_reg, pc2_reg, state_reg};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // Strobe select for the current access
  wire upper = acc_addr_reg[`UPPER_AREA_BIT] &&
               !is_big(addr_mux_code, bus16);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      acc_addr_reg <= 26'h000_0000;
      acc_area_reg <= 1'b0;
      wait_reg <= 2'h0;
      beat_reg <= 2'h0;
      addr_pin_reg <= 26'h000_0000;
      cs2_n_reg <= 1'b1;
      cs3_n_reg <= 1'b1;
      row_strobe_upper_n_reg <= 1'b1;
      row_strobe_lower_n_reg <= 1'b1;
      col_strobe_upper_n_reg <= 1'b1;
      col_strobe_lower_n_reg <= 1'b1;
      rd_wr_reg <= 1'b1;
    end else begin
      // Default is a NOP with chip selects released
      cs2_n_reg <= 1'b1;
      cs3_n_reg <= 1'b1;
      row_strobe_upper_n_reg <= 1'b1;
      row_strobe_lower_n_reg <= 1'b1;
      col_strobe_upper_n_reg <= 1'b1;
      col_strobe_lower_n_reg <= 1'b1;
      rd_wr_reg <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          if (req_valid && req_ready) begin
            acc_addr_reg <= req_addr;
            acc_area_reg <= req_area;
            wait_reg <= act_to_read_delay;
            addr_pin_reg <= row_pins(req_addr, addr_mux_code, bus16);
            cs2_n_reg <= req_area;
            cs3_n_reg <= !req_area;
            if (req_addr[`UPPER_AREA_BIT] && !is_big(addr_mux_code, bus16))
              row_strobe_upper_n_reg <= 1'b0;
            else
              row_strobe_lower_n_reg <= 1'b0;
            state_reg <= S_ACT;
          end
        end
        S_ACT, S_NOP_WAIT: begin
          cs2_n_reg <= acc_area_reg;
          cs3_n_reg <= !acc_area_reg;
          if (wait_reg == 2'h0) begin
            beat_reg <= 2'h0;
            addr_pin_reg <= col_pins(acc_addr_reg, addr_mux_code, bus16, 1'b0);
            col_strobe_upper_n_reg <= !upper;
            col_strobe_lower_n_reg <= upper;
            state_reg <= S_COL;
          end else begin
            // Extra delay cycles carry NOP
            wait_reg <= wait_reg - 2'h1;
            state_reg <= S_NOP_WAIT;
          end
        end
        S_COL: begin
          if (beat_reg == `LAST_BEAT) begin
            state_reg <= S_DRAIN;
          end else begin
            cs2_n_reg <= acc_area_reg;
            cs3_n_reg <= !acc_area_reg;
            beat_reg <= beat_reg + 2'h1;
            addr_pin_reg <= col_pins(beat_addr(acc_addr_reg, beat_reg + 2'h1, bus16),
                                     addr_mux_code, bus16,
                                     beat_reg + 2'h1 == `LAST_BEAT);
            col_strobe_upper_n_reg <= !upper;
            col_strobe_lower_n_reg <= upper;
          end
        end
        S_DRAIN: begin
          if (last_capture)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Each READ issued is tracked down the pipe until its data arrives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_pipe_reg <= 3'h0;
      cap_reg <= 3'h0;
      rdata_reg <= 32'h0000_0000;
      rdata_valid_reg <= 1'b0;
      rdata_last_reg <= 1'b0;
    end else begin
      issue_pipe_reg <= {issue_pipe_reg[1:0], state_reg == S_COL};
      rdata_valid_reg <= capture;
      rdata_last_reg <= last_capture;
      if (capture) begin
        rdata_reg <= dq_in;
        cap_reg <= last_capture ? 3'h0 : cap_reg + 3'h1;
      end
    end
  end

  // Precharge wait per area, started with the last data beat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc2_reg <= 4'h0;
      pc3_reg <= 4'h0;
    end else begin
      if (last_capture && !acc_area_reg)
        pc2_reg <= {1'b0, tpc} + 4'h1;
      else if (pc2_reg != 4'h0)
        pc2_reg <= pc2_reg - 4'h1;
      if (last_capture && acc_area_reg)
        pc3_reg <= {1'b0, tpc} + 4'h1;
      else if (pc3_reg != 4'h0)
        pc3_reg <= pc3_reg - 4'h1;
    end
  end

endmodule

// [verilog/sdram_mux_regs.vh]
/*
 * Register offsets, field positions, reset values and pin codes for the
 * synchronous DRAM address multiplexer and burst read engine.
 * Assumes a 32-bit APB slave port with byte addresses.
 */
`ifndef SDRAM_MUX_REGS_VH
`define SDRAM_MUX_REGS_VH

`define MEMORY_CONTROL_OFFSET 12'h000
`define WAIT_CONTROL_TWO_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

// memory_control_reg fields
`define MUX_CODE_LSB 0
`define MUX_CODE_MSB 3
`define ACT_DELAY_LSB 4
`define ACT_DELAY_MSB 5
`define TPC_LSB 6
`define TPC_MSB 8
`define BUS16_BIT 9
`define MEMORY_CONTROL_MASK 32'h0000_03ff
`define MEMORY_CONTROL_RESET 32'h0000_0004

// wait_control_reg_two fields: CAS latency of area 2 and area 3
`define CL2_LSB 0
`define CL2_MSB 1
`define CL3_LSB 2
`define CL3_MSB 3
`define WAIT_CONTROL_TWO_MASK 32'h0000_000f
`define WAIT_CONTROL_TWO_RESET 32'h0000_0005

// Multiplex codes
`define CODE_2M16 4'h5
`define CODE_1M16 4'h4
`define CODE_512K32 4'h7
`define CODE_8M16 4'he
// 4M x 16 geometry, on a 32-bit bus only (CODE_8M16 takes its place on a 16-bit bus)
`define CODE_BIG 4'hd

// Pin positions in the multiplexed field, and the address bit that selects the upper strobes
`define MUX_LO 1
`define MUX_HI 16
`define CMD_PIN_32 12
`define CMD_PIN_16 11
`define ODD_PIN 15
`define UPPER_AREA_BIT 25

`define BEATS 3'h4
`define LAST_BEAT 2'h3

`endif
